// ==== logic/sfce_engine.sv ====
// Serial flash command decoder, array and self-timed cycle sequencer
`timescale 1ns/10ps
// Functional notes
// - Status write refused in hardware lock
// - Lock whenever disable bit set, pin low
// - Pin high releases lock; bits still protect
// - Sample on rising, shift out falling
// - Reads auto-increment address, wrap to zero
// - Fast read has one dummy byte
// - Fast read ignored while busy
// - Sector erase uses address bits fifteen-twelve
// - Select rise off byte boundary discards
// - Erase busy then clears busy, latch
// - No erase of protected region
// - Chip erase only with zero protect
// - Page data wraps inside the page
// - Only last 256 page bytes kept
// - Unsent page bytes stay unchanged
// - Page write busy, clears latch, skips protected
// - Sleep ignores all but wake, signature
// - Sleep entered after fixed delay
// - Wake needs rise on a byte boundary after opcode
// - Status byte field layout
module sfce_engine import sfce_pkg::*; #(
  parameter int unsigned PROG_CYC = CYC_PROG,
  parameter int unsigned SECT_CYC = CYC_SECT,
  parameter int unsigned BLK_CYC = CYC_BLK,
  parameter int unsigned CE_CYC = CYC_CE,
  parameter int unsigned W_CYC = CYC_W
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic write_protect_n,
  output logic so,
  output logic so_oe,
  output logic busy_flag,
  output logic write_enable_latch,
  output logic protect_level_hi,
  output logic protect_level_lo,
  output logic status_write_disable,
  output logic hardware_lock_mode,
  output logic deep_sleep
);
  logic [3:0] pin_q, pin_rise, pin_fall;
  logic cs_q, sck_rise, sck_fall, si_q, wp_q, cs_rise, cs_fall;
  logic [7:0] mem [0:(1 << ADDR_W) - 1];
  logic [7:0] pbuf [0:255];
  sfce_spi_type state_r, state_nxt;
  sfce_eng_type eng_r, eng_nxt;
  logic [7:0] op_r, op_nxt, sreg_r, sreg_nxt, out_r, out_nxt, col_r, col_nxt;
  logic [7:0] stnew_r, stnew_nxt;
  logic [2:0] bit_r, bit_nxt;
  logic [1:0] abyte_r, abyte_nxt, bp_r, bp_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt, wa_r, wa_nxt, wend_r, wend_nxt;
  logic [255:0] pmask_r, pmask_nxt;
  logic [31:0] tmr_r, tmr_nxt;
  logic [15:0] dpc_r, dpc_nxt;
  logic exec_r, exec_nxt, arm_r, arm_nxt, wdis_r, wdis_nxt, sleep_r, sleep_nxt;
  logic dpp_r, dpp_nxt, so_nxt, oe_nxt, lock_nxt, busy_nxt;
  logic mem_we, pb_we, ok;
  logic [ADDR_W-1:0] mem_wa, a16;
  logic [7:0] mem_wd, nb, stat;

  sfce_pin_sync #(.W(4), .RST_VAL(4'b1001)) u_sync (
    .clk(ref_clk),
    .resetn(resetn),
    .d({write_protect_n, si, sck, cs_n}),
    .q(pin_q),
    .rise(pin_rise),
    .fall(pin_fall)
  );
  assign cs_q = pin_q[0];
  assign sck_rise = pin_rise[1];
  assign sck_fall = pin_fall[1];
  assign si_q = pin_q[2];
  assign wp_q = pin_q[3];
  assign cs_rise = pin_rise[0];
  assign cs_fall = pin_fall[0];

  function automatic logic sec_prot(input logic [3:0] sec, input logic [1:0] bp);
    case (bp)
      2'd0: sec_prot = 1'b0;
      2'd1: sec_prot = (sec >= PROT_QTR_SEC);
      2'd2: sec_prot = (sec >= PROT_HALF_SEC);
      default: sec_prot = 1'b1;
    endcase
  endfunction

  always_comb begin
    state_nxt = state_r;
    eng_nxt = eng_r;
    op_nxt = op_r;
    sreg_nxt = sreg_r;
    out_nxt = out_r;
    col_nxt = col_r;
    stnew_nxt = stnew_r;
    bit_nxt = bit_r;
    abyte_nxt = abyte_r;
    bp_nxt = bp_r;
    addr_nxt = addr_r;
    wa_nxt = wa_r;
    wend_nxt = wend_r;
    pmask_nxt = pmask_r;
    tmr_nxt = tmr_r;
    dpc_nxt = dpc_r;
    exec_nxt = exec_r;
    arm_nxt = arm_r;
    wdis_nxt = wdis_r;
    sleep_nxt = sleep_r;
    dpp_nxt = dpp_r;
    so_nxt = so;
    oe_nxt = so_oe;
    mem_we = 1'b0;
    mem_wa = wa_r;
    mem_wd = 8'hff;
    pb_we = 1'b0;
    nb = {sreg_r[6:0], si_q};
    a16 = {addr_r[7:0], nb};
    stat = '0;
    stat[ST_BUSY] = busy_flag;
    stat[ST_ARMED] = arm_r;
    stat[ST_BP_LSB +: 2] = bp_r;
    stat[ST_WDIS] = wdis_r;
    ok = exec_r && (state_r == SP_TAIL || state_r == SP_PDATA);
    // Array sweeps run one byte a clock, then the timer counts down its full load after the sweep
    case (eng_r)
      EN_WIPE: begin
        mem_we = 1'b1;
        if (wa_r == wend_r) begin
          eng_nxt = EN_WAIT;
        end else begin
          wa_nxt = wa_r + 1'b1;
        end
      end
      EN_PROG: begin
        mem_we = pmask_r[col_r];
        mem_wa = {addr_r[ADDR_W-1:PAGE_LSB], col_r};
        mem_wd = mem[mem_wa] & pbuf[col_r];
        col_nxt = col_r + 1'b1;
        if (col_r == 8'hff) begin
          eng_nxt = EN_WAIT;
        end
      end
      EN_WAIT: begin
        if (tmr_r == '0) begin
          eng_nxt = EN_IDLE;
          arm_nxt = 1'b0;
        end else begin
          tmr_nxt = tmr_r - 1'b1;
        end
      end
      default: ;
    endcase
    if (dpp_r) begin
      if (dpc_r == '0) begin
        dpp_nxt = 1'b0;
        sleep_nxt = 1'b1;
      end else begin
        dpc_nxt = dpc_r - 1'b1;
      end
    end
    if (cs_fall) begin
      state_nxt = SP_CMD;
      bit_nxt = '0;
      exec_nxt = 1'b0;
    end else if (cs_rise && state_r != SP_IDLE) begin
      state_nxt = SP_IDLE;
      oe_nxt = 1'b0;
      if (ok) begin
        case (op_r)
          OP_ARM: arm_nxt = 1'b1;
          OP_DISARM: arm_nxt = 1'b0;
          OP_WAKE: sleep_nxt = 1'b0;
          OP_SLEEP: begin
            dpp_nxt = 1'b1;
            dpc_nxt = 16'(CYC_SLEEP - 1);
          end
          OP_WRSTAT: begin
            if (arm_r && !hardware_lock_mode) begin
              wdis_nxt = stnew_r[ST_WDIS];
              bp_nxt = stnew_r[ST_BP_LSB +: 2];
              eng_nxt = EN_WAIT;
              tmr_nxt = W_CYC - 1;
            end
          end
          OP_SECT: begin
            if (arm_r && !sec_prot(addr_r[ADDR_W-1:SECT_LSB], bp_r)) begin
              wa_nxt = {addr_r[ADDR_W-1:SECT_LSB], 12'h000};
              wend_nxt = {addr_r[ADDR_W-1:SECT_LSB], 12'hfff};
              eng_nxt = EN_WIPE;
              tmr_nxt = SECT_CYC - 1;
            end
          end
          OP_BLOCK, OP_CHIP: begin
            if (arm_r && bp_r == 2'b00) begin
              wa_nxt = '0;
              wend_nxt = '1;
              eng_nxt = EN_WIPE;
              tmr_nxt = (op_r == OP_CHIP) ? CE_CYC - 1 : BLK_CYC - 1;
            end
          end
          OP_PAGE: begin
            if (arm_r && !sec_prot(addr_r[ADDR_W-1:SECT_LSB], bp_r)) begin
              col_nxt = '0;
              eng_nxt = EN_PROG;
              tmr_nxt = PROG_CYC - 1;
            end
          end
          default: ;
        endcase
      end else if (state_r == SP_SIG && sleep_r && bit_r == 3'd0) begin
        // wake on whole byte
        // A cut byte after the opcode must leave the device asleep
        sleep_nxt = 1'b0;
      end
    end else if (!cs_q && sck_rise) begin
      sreg_nxt = nb;
      bit_nxt = bit_r + 1'b1;
      exec_nxt = 1'b0;
      if (bit_r == 3'd7) begin
        case (state_r)
          SP_CMD: begin
            op_nxt = nb;
            abyte_nxt = '0;
            state_nxt = SP_SKIP;
            if (eng_r != EN_IDLE || dpp_r) begin
              if (nb == OP_RDSTAT) begin
                state_nxt = SP_STAT;
                out_nxt = stat;
              end
            end else if (sleep_r) begin
              if (nb == OP_WAKE) begin
                state_nxt = SP_SIG;
                out_nxt = SIG_VALUE;
                exec_nxt = 1'b1;
              end
            end else begin
              case (nb)
                OP_READ, OP_FAST, OP_SECT, OP_BLOCK, OP_PAGE: state_nxt = SP_ADDR;
                OP_CHIP, OP_ARM, OP_DISARM, OP_SLEEP: begin
                  state_nxt = SP_TAIL;
                  exec_nxt = 1'b1;
                end
                OP_WAKE: begin
                  state_nxt = SP_SIG;
                  out_nxt = SIG_VALUE;
                end
                OP_RDSTAT: begin
                  state_nxt = SP_STAT;
                  out_nxt = stat;
                end
                OP_WRSTAT: state_nxt = SP_SDATA;
                default: state_nxt = SP_SKIP;
              endcase
            end
          end
          SP_ADDR: begin
            addr_nxt = a16;
            abyte_nxt = abyte_r + 1'b1;
            if (abyte_r == 2'd2) begin
              case (op_r)
                OP_READ: begin
                  state_nxt = SP_READ;
                  out_nxt = mem[a16];
                end
                OP_FAST: state_nxt = SP_DUMMY;
                OP_PAGE: begin
                  state_nxt = SP_PDATA;
                  col_nxt = nb;
                  pmask_nxt = '0;
                end
                default: begin
                  state_nxt = SP_TAIL;
                  exec_nxt = 1'b1;
                end
              endcase
            end
          end
          SP_DUMMY: begin
            state_nxt = SP_READ;
            out_nxt = mem[addr_r];
          end
          SP_READ: begin
            addr_nxt = addr_r + 1'b1;
            out_nxt = mem[addr_nxt];
          end
          SP_STAT: out_nxt = stat;
          SP_SIG: begin
            out_nxt = SIG_VALUE;
            exec_nxt = 1'b0;
          end
          SP_PDATA: begin
            pb_we = 1'b1;
            pmask_nxt[col_r] = 1'b1;
            col_nxt = col_r + 1'b1;
            exec_nxt = 1'b1;
          end
          SP_SDATA: begin
            stnew_nxt = nb;
            state_nxt = SP_TAIL;
            exec_nxt = 1'b1;
          end
          default: ;
        endcase
      end
    end else if (!cs_q && sck_fall &&
                 (state_r == SP_READ || state_r == SP_STAT || state_r == SP_SIG)) begin
      so_nxt = out_r[7];
      oe_nxt = 1'b1;
      out_nxt = {out_r[6:0], 1'b0};
    end
    lock_nxt = wdis_nxt && !wp_q;
    busy_nxt = (eng_nxt != EN_IDLE);
  end

  always_ff @(posedge ref_clk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
    if (pb_we) begin
      pbuf[col_r] <= nb;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state_r <= SP_IDLE;
      eng_r <= EN_IDLE;
      op_r <= '0;
      sreg_r <= '0;
      out_r <= '0;
      col_r <= '0;
      stnew_r <= '0;
      bit_r <= '0;
      abyte_r <= '0;
      bp_r <= BP_RST;
      addr_r <= '0;
      wa_r <= '0;
      wend_r <= '0;
      pmask_r <= '0;
      tmr_r <= '0;
      dpc_r <= '0;
      exec_r <= 1'b0;
      arm_r <= 1'b0;
      wdis_r <= WDIS_RST;
      sleep_r <= 1'b0;
      dpp_r <= 1'b0;
      so <= 1'b0;
      so_oe <= 1'b0;
      hardware_lock_mode <= 1'b0;
      busy_flag <= 1'b0;
    end else begin
      state_r <= state_nxt;
      eng_r <= eng_nxt;
      op_r <= op_nxt;
      sreg_r <= sreg_nxt;
      out_r <= out_nxt;
      col_r <= col_nxt;
      stnew_r <= stnew_nxt;
      bit_r <= bit_nxt;
      abyte_r <= abyte_nxt;
      bp_r <= bp_nxt;
      addr_r <= addr_nxt;
      wa_r <= wa_nxt;
      wend_r <= wend_nxt;
      pmask_r <= pmask_nxt;
      tmr_r <= tmr_nxt;
      dpc_r <= dpc_nxt;
      exec_r <= exec_nxt;
      arm_r <= arm_nxt;
      wdis_r <= wdis_nxt;
      sleep_r <= sleep_nxt;
      dpp_r <= dpp_nxt;
      so <= so_nxt;
      so_oe <= oe_nxt;
      hardware_lock_mode <= lock_nxt;
      busy_flag <= busy_nxt;
    end
  end

  assign write_enable_latch = arm_r;
  assign protect_level_hi = bp_r[1];
  assign protect_level_lo = bp_r[0];
  assign status_write_disable = wdis_r;
  assign deep_sleep = sleep_r;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  sequence s_cmd_byte;
    !cs_q && sck_rise && bit_r == 3'd7 && state_r == SP_CMD;
  endsequence
  sequence s_sleep_req;
    cs_rise && ok && op_r == OP_SLEEP;
  endsequence
  lock_tracks_a: assert property (
    hardware_lock_mode == $past(wdis_r && !wp_q) || $past(cs_rise))
    else $error("lock mode mismatch");
  wrsr_lock_a: assert property (
    cs_rise && op_r == OP_WRSTAT && hardware_lock_mode |=>
      wdis_r == $past(wdis_r) && bp_r == $past(bp_r))
    else $error("status written under lock");
  read_incr_a: assert property (
    !cs_q && sck_rise && bit_r == 3'd7 && state_r == SP_READ && !cs_fall |=>
      addr_r == $past(addr_r) + 1'b1)
    else $error("read address not advanced");
  fast_busy_a: assert property (
    s_cmd_byte ##0 (eng_r != EN_IDLE && nb == OP_FAST && !cs_fall) |=>
      state_r == SP_SKIP && eng_r != EN_IDLE)
    else $error("fast read taken while busy");
  cycle_end_a: assert property (
    eng_r == EN_WAIT && tmr_r == '0 |=> !busy_flag && !write_enable_latch)
    else $error("cycle end flags wrong");
  bound_drop_a: assert property (
    cs_rise && !exec_r && eng_r == EN_IDLE && (op_r == OP_SECT || op_r == OP_PAGE) |=>
      eng_r == EN_IDLE)
    else $error("off-boundary command ran");
  chip_prot_a: assert property (
    cs_rise && op_r == OP_CHIP && bp_r != 2'b00 && eng_r == EN_IDLE |=> eng_r == EN_IDLE)
    else $error("chip erase ran while protected");
  sleep_delay_a: assert property (
    s_sleep_req ##0 !sleep_r |=> !deep_sleep [*8])
    else $error("sleep entered too early");
  so_on_fall_a: assert property (
    so != $past(so) |-> $past(sck_fall))
    else $error("data changed off falling edge");
  page_wrap_a: assert property (
    !cs_q && sck_rise && bit_r == 3'd7 && state_r == SP_PDATA && !cs_fall |=>
      col_r == 8'($past(col_r) + 1'b1))
    else $error("page column not wrapped");
  wake_bound_a: assert property (
    cs_rise && state_r == SP_SIG && sleep_r && bit_r != 3'd0 |=> deep_sleep)
    else $error("woken by a cut frame");
endmodule

// ==== logic/sfce_pin_sync.sv ====
// Three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/10ps
module sfce_pin_sync #(
  parameter int W = 4,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] s1_r, s2_r, s3_r;
  logic [W-1:0] q_nxt, rise_nxt, fall_nxt;

  // A change counts only once stages two and three agree
  always_comb begin
    q_nxt = q;
    for (int i = 0; i < W; i++) begin
      if (s2_r[i] == s3_r[i]) begin
        q_nxt[i] = s3_r[i];
      end
    end
    rise_nxt = q_nxt & ~q;
    fall_nxt = ~q_nxt & q;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
      q <= RST_VAL;
      rise <= '0;
      fall <= '0;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q <= q_nxt;
      rise <= rise_nxt;
      fall <= fall_nxt;
    end
  end
endmodule

// ==== logic/sfce_pkg.sv ====
// Shared constants and types for the serial flash command engine
package sfce_pkg;
  localparam int CLK_MHZ = 50;
  localparam int ADDR_W = 16;
  localparam int SECT_LSB = 12;
  localparam int PAGE_LSB = 8;
  localparam logic [3:0] PROT_QTR_SEC = 4'hc;
  localparam logic [3:0] PROT_HALF_SEC = 4'h8;
  // Opcodes
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FAST = 8'h0b;
  localparam logic [7:0] OP_SECT = 8'h20;
  localparam logic [7:0] OP_BLOCK = 8'h52;
  localparam logic [7:0] OP_CHIP = 8'h60;
  localparam logic [7:0] OP_PAGE = 8'h02;
  localparam logic [7:0] OP_SLEEP = 8'hb9;
  localparam logic [7:0] OP_WAKE = 8'hab;
  localparam logic [7:0] OP_ARM = 8'h06;
  localparam logic [7:0] OP_DISARM = 8'h04;
  localparam logic [7:0] OP_RDSTAT = 8'h05;
  localparam logic [7:0] OP_WRSTAT = 8'h01;
  // Arbitrary signature value, names no real part
  localparam logic [7:0] SIG_VALUE = 8'h5a;
  // Status byte layout
  localparam int ST_BUSY = 0;
  localparam int ST_ARMED = 1;
  localparam int ST_BP_LSB = 2;
  localparam int ST_WDIS = 7;
  localparam logic WDIS_RST = 1'b0;
  localparam logic [1:0] BP_RST = 2'b00;
  // Self-timed cycles in microseconds and their clock counts
  localparam int T_PROG_US = 1400;
  localparam int T_SECT_US = 60000;
  localparam int T_BLK_US = 60000;
  localparam int T_CE_US = 1000000;
  localparam int T_W_US = 15000;
  localparam int T_SLEEP_US = 3;
  localparam int CYC_PROG = T_PROG_US * CLK_MHZ;
  localparam int CYC_SECT = T_SECT_US * CLK_MHZ;
  localparam int CYC_BLK = T_BLK_US * CLK_MHZ;
  localparam int CYC_CE = T_CE_US * CLK_MHZ;
  localparam int CYC_W = T_W_US * CLK_MHZ;
  localparam int CYC_SLEEP = T_SLEEP_US * CLK_MHZ;
  typedef enum logic [3:0] {
    SP_IDLE, SP_CMD, SP_ADDR, SP_DUMMY, SP_READ, SP_STAT, SP_SIG, SP_PDATA, SP_SDATA,
    SP_TAIL, SP_SKIP
  } sfce_spi_type;
  typedef enum logic [1:0] {EN_IDLE, EN_WIPE, EN_PROG, EN_WAIT} sfce_eng_type;
endpackage

// ==== tb/sfce_engine_tb_top.sv ====
// Self-checking bench for the serial flash command engine
`timescale 1ns/10ps
module sfce_engine_tb_top import sfce_pkg::*; ();
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic write_protect_n = 1'b1;
  logic cs_n, sck, si, so, so_oe, busy_flag, write_enable_latch, deep_sleep;
  logic protect_level_hi, protect_level_lo, status_write_disable, hardware_lock_mode;
  int miscompares = 0;
  int n_compared = 0;
  logic [7:0] rx;
  logic [7:0] st;
  assign st = {status_write_disable, 3'h0, protect_level_hi, protect_level_lo,
               write_enable_latch, busy_flag};
  // Long program time keeps the cycle alive across a whole refused frame
  sfce_engine #(.PROG_CYC(400), .SECT_CYC(20), .BLK_CYC(20), .CE_CYC(20), .W_CYC(20)) dut (
    .ref_clk(ref_clk), .resetn(resetn), .cs_n(cs_n), .sck(sck), .si(si),
    .write_protect_n(write_protect_n), .so(so), .so_oe(so_oe), .busy_flag(busy_flag),
    .write_enable_latch(write_enable_latch), .protect_level_hi(protect_level_hi),
    .protect_level_lo(protect_level_lo), .status_write_disable(status_write_disable),
    .hardware_lock_mode(hardware_lock_mode), .deep_sleep(deep_sleep));
  sfce_host_model h (
    .ref_clk(ref_clk), .so(so), .so_oe(so_oe), .cs_n(cs_n), .sck(sck), .si(si));
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic op(input logic [7:0] code, input logic [31:0] adr, input int nadr);
    h.start();
    h.shift(code, 8, rx);
    for (int k = nadr - 1; k >= 0; k--) begin
      h.shift(8'(adr >> (8 * k)), 8, rx);
    end
  endtask
  task automatic arm();
    op(OP_ARM, 0, 0);
    h.stop();
  endtask
  task automatic wrstat(input logic [7:0] v);
    arm();
    op(OP_WRSTAT, {24'h0, v}, 1);
    h.stop();
  endtask
  task automatic rd(input logic [7:0] code, input logic [31:0] adr, input int nadr,
                    input logic [7:0] e [4]);
    op(code, adr, nadr);
    foreach (e[k]) begin
      h.shift(8'h00, 8, rx);
      chk("read_byte", e[k], rx);
    end
    h.stop();
  endtask
  task automatic settle(input logic bexp, input int lim);
    int n;
    logic seen;
    n = 0;
    seen = (busy_flag === 1'b1);
    while (!seen && n < 20) begin
      @(posedge ref_clk);
      seen = (busy_flag === 1'b1);
      n++;
    end
    chk("busy_start", {7'h0, bexp}, {7'h0, seen});
    n = 0;
    while (busy_flag === 1'b1 && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
    chk("busy_end", 8'h00, {7'h0, busy_flag});
    if (bexp) begin
      chk("latch_after_cycle", 8'h00, {7'h0, write_enable_latch});
    end
  endtask
  task automatic pin_lock(input logic pin, input logic [7:0] exp);
    write_protect_n <= pin;
    repeat (10) @(posedge ref_clk);
    chk("lock", exp, {7'h0, hardware_lock_mode});
  endtask
  task automatic t_lock();
    pin_lock(1'b0, 8'h00);
    wrstat(8'h84);
    settle(1'b1, 200);
    chk("status", 8'h84, st);
    chk("lock", 8'h01, {7'h0, hardware_lock_mode});
    op(OP_RDSTAT, 0, 0);
    h.shift(8'h00, 8, rx);
    h.stop();
    chk("status_read", 8'h84, rx);
    wrstat(8'h0c);
    settle(1'b0, 20);
    chk("status", 8'h86, st);
    pin_lock(1'b1, 8'h00);
    pin_lock(1'b0, 8'h01);
    pin_lock(1'b1, 8'h00);
  endtask
  task automatic t_prot();
    logic [7:0] ops [3] = '{OP_CHIP, OP_BLOCK, OP_SECT};
    foreach (ops[k]) begin
      op(ops[k], 32'h00f123, ops[k] == OP_CHIP ? 0 : 3);
      h.stop();
      settle(1'b0, 20);
      chk("status", 8'h86, st);
    end
    wrstat(8'h00);
    settle(1'b1, 200);
    op(OP_SECT, 32'h000abc, 3);
    h.stop();
    settle(1'b0, 20);
    arm();
    op(OP_SECT, 32'h000abc, 2);
    h.shift(8'hbc, 4, rx);
    h.stop();
    settle(1'b0, 20);
    chk("status", 8'h02, st);
  endtask
  task automatic t_erase_page();
    op(OP_SECT, 32'h000abc, 3);
    h.stop();
    settle(1'b1, 4400);
    arm();
    op(OP_SECT, 32'h00f123, 3);
    h.stop();
    settle(1'b1, 4400);
    arm();
    op(OP_PAGE, 32'h00fffe, 3);
    h.shift(8'ha1, 8, rx);
    h.shift(8'ha2, 8, rx);
    h.shift(8'ha3, 8, rx);
    h.stop();
    settle(1'b1, 900);
    rd(OP_FAST, 32'hfffd00, 4, '{8'hff, 8'ha1, 8'ha2, 8'hff});
    h.stretch = 4;
    rd(OP_READ, 32'h00ff00, 3, '{8'ha3, 8'hff, 8'hff, 8'hff});
    h.stretch = 0;
  endtask
  task automatic t_busy_page();
    arm();
    op(OP_PAGE, 32'h000010, 3);
    for (int k = 0; k <= 256; k++) begin
      h.shift(k == 256 ? 8'h77 : 8'(k), 8, rx);
    end
    h.stop();
    op(OP_FAST, 32'h0, 4);
    chk("busy_mid", 8'h01, {7'h0, busy_flag});
    h.shift(8'h00, 8, rx);
    h.stop();
    chk("drive_while_busy", 8'h00, {7'h0, h.oe_seen});
    settle(1'b1, 900);
    rd(OP_FAST, 32'h1000, 4, '{8'h77, 8'h01, 8'h02, 8'h03});
  endtask
  task automatic t_sleep();
    op(OP_SLEEP, 0, 0);
    h.stop();
    repeat (100) @(posedge ref_clk);
    chk("sleep_early", 8'h00, {7'h0, deep_sleep});
    repeat (60) @(posedge ref_clk);
    chk("sleep_entered", 8'h01, {7'h0, deep_sleep});
    arm();
    chk("status", 8'h00, st);
    op(OP_WAKE, 0, 0);
    h.shift(8'h00, 4, rx);
    h.stop();
    chk("sleep_kept", 8'h01, {7'h0, deep_sleep});
    op(OP_WAKE, 0, 0);
    h.stop();
    chk("sleep_left", 8'h00, {7'h0, deep_sleep});
  endtask
  task automatic report_and_stop();
    if (miscompares == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (6) @(posedge ref_clk);
    chk("status_reset", 8'h00, st);
    t_lock();
    t_prot();
    t_erase_page();
    t_busy_page();
    t_sleep();
    report_and_stop();
  end
  // Run needs about 35k clocks; this allows more than twice that
  initial begin
    #1600000;
    miscompares++;
    report_and_stop();
  end
endmodule

// ==== tb/sfce_host_model.sv ====
// Host controller model driving the serial flash link
`timescale 1ns/10ps
module sfce_host_model (
  input wire logic ref_clk,
  input wire logic so,
  input wire logic so_oe,
  output logic cs_n,
  output logic sck,
  output logic si
);
  int stretch = 0;
  logic oe_seen = 1'b0;
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end
  // Catches any drive of the return line inside a frame
  always @(posedge ref_clk) begin
    if (so_oe === 1'b1) begin
      oe_seen <= 1'b1;
    end
  end
  task automatic start();
    @(posedge ref_clk);
    cs_n <= 1'b0;
    oe_seen <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask
  // msb first, rise samples
  // Return data is taken late in the high phase to cover synchroniser lag
  task automatic shift(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nbits; i--) begin
      sck <= 1'b0;
      si <= tx[i];
      repeat (4 + stretch) @(posedge ref_clk);
      sck <= 1'b1;
      repeat (4) @(posedge ref_clk);
      rx[i] = so;
    end
  endtask
  task automatic stop();
    sck <= 1'b0;
    si <= ~si;
    repeat (4) @(posedge ref_clk);
    cs_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
  endtask
endmodule
